// ### rtl/plio_defs.svh
// Constants for the port load, pointer increment and immediate load decoder.
// Assumes a 10-bit instruction word and a 4-bit accumulator and pointer.
`ifndef PLIO_DEFS_SVH
`define PLIO_DEFS_SVH
`define PLIO_OP_PORT_TWO 10'h262
`define PLIO_OP_PORT_THREE 10'h263
`define PLIO_OP_INC_Y 10'h013
`define PLIO_LA_MASK 10'h3F0
`define PLIO_LA_MATCH 10'h070
`define PLIO_ACC_RST 4'h0
`define PLIO_Y_RST 4'h0
`endif

// ### rtl/plio_pkg.sv
// Types for the port load, pointer increment and immediate load decoder.
// Assumes the constants header is included by the files that need numbers.
package plio_pkg;
  typedef enum logic [2:0] {
    PLIO_OP_NONE = 3'b000,
    PLIO_OP_P2 = 3'b001,
    PLIO_OP_P3 = 3'b010,
    PLIO_OP_INCY = 3'b011,
    PLIO_OP_LA = 3'b100
  } plio_op_t;
  typedef struct packed {
    logic valid;
    logic [9:0] word;
  } plio_instr_t;
  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] yPtr;
    logic skipNext;
  } plio_state_t;
endpackage

// ### rtl/plio_decode.sv
// Instruction word decoder for the four handled opcodes.
// Assumes a registered instruction word from the fetch path.
`include "plio_defs.svh"
module plio_decode
  import plio_pkg::*;
(
  input wire logic [9:0] word,
  output plio_op_t op
);
  wire isP2 = (word == `PLIO_OP_PORT_TWO);
  wire isP3 = (word == `PLIO_OP_PORT_THREE);
  wire isIncY = (word == `PLIO_OP_INC_Y);
  wire isLa = ((word & `PLIO_LA_MASK) == `PLIO_LA_MATCH);
  assign op = isP2 ? PLIO_OP_P2 : isP3 ? PLIO_OP_P3 : isIncY ? PLIO_OP_INCY :
              isLa ? PLIO_OP_LA : PLIO_OP_NONE;
endmodule

// ### rtl/plio_core.sv
// Execute stage for port loads, pointer increment and immediate loads.
// Assumes one instruction per ref_clk when instr.valid is high, and pins
// that are asynchronous to ref_clk.
//
// What this block does
// - Opcode 262h copies the two second input port pins into accumulator bits 1 and 0.
// - During the second-port read, accumulator bits 3 and 2 are forced to zero.
// - Opcode 263h loads the third input port pins into bits 1 and 0 and clears bits 3 and 2.
// - Opcode 013h increments the Y pointer and requests a skip when the result is zero.
// - The immediate load writes its 4-bit immediate into the accumulator.
// - In a run of immediate loads only the first executes and the rest are skipped.
`include "plio_defs.svh"
module plio_core
  import plio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input plio_instr_t instr,
  input wire logic [1:0] second_input_port,
  input wire logic [1:0] third_input_port,
  input wire logic carryIn,
  output logic [3:0] accOut,
  output logic [3:0] yOut,
  output logic skipNextOut,
  output logic carryOut
);

  // Port reads keep the two pins and zero the upper accumulator half.
  function automatic logic [3:0] portToAcc(input logic [1:0] pins);
    return {2'b00, pins};
  endfunction

  // The pointer wraps from fifteen back to zero.
  function automatic logic [3:0] wrapInc(input logic [3:0] value);
    return 4'(value + 4'h1);
  endfunction

  // The skip fires on a zero result.
  function automatic logic isZero(input logic [3:0] value);
    return value == 4'h0;
  endfunction

  // Immediate loads start or extend a run.
  function automatic logic isLoadCode(input plio_op_t code);
    return code == PLIO_OP_LA;
  endfunction

  // Opcodes that change the accumulator.
  function automatic logic writesAcc(input plio_op_t code);
    case (code)
      PLIO_OP_P2: return 1'b1;
      PLIO_OP_P3: return 1'b1;
      PLIO_OP_LA: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Opcodes that change the pointer and may ask for a skip.
  function automatic logic writesY(input plio_op_t code);
    case (code)
      PLIO_OP_INCY: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Picks the new accumulator value for an opcode that writes it.
  function automatic logic [3:0] selectAcc(
    input plio_op_t code,
    input logic [3:0] fromPortTwo,
    input logic [3:0] fromPortThree,
    input logic [3:0] fromWord,
    input logic [3:0] current
  );
    case (code)
      PLIO_OP_P2: return fromPortTwo;
      PLIO_OP_P3: return fromPortThree;
      PLIO_OP_LA: return fromWord;
      default: return current;
    endcase
  endfunction

  logic [1:0] p2Meta_ff;
  logic [1:0] p2Sync_ff;
  logic [1:0] p3Meta_ff;
  logic [1:0] p3Sync_ff;
  logic [3:0] acc_ff;
  logic [3:0] y_ff;
  logic skip_ff;
  plio_state_t nxt_state;
  logic lastLa_ff;
  logic nxt_lastLa;
  logic carry_ff;
  logic nxt_carry;
  plio_op_t op;

  plio_decode uDecode (
    .word(instr.word),
    .op(op)
  );

  // Fields of the incoming word and the current state.
  wire instrValid = instr.valid;
  wire [3:0] immediate = instr.word[3:0];
  wire [3:0] accNow = acc_ff;
  wire [3:0] yNow = y_ff;
  wire isLoad = isLoadCode(op);

  // An immediate load straight after another one is skipped.
  wire laSkip = isLoad && lastLa_ff;
  wire exec = instrValid && !laSkip;
  wire accWrite = exec && writesAcc(op);
  wire yWrite = exec && writesY(op);

  // Candidate results of each opcode.
  wire [3:0] p2Value = portToAcc(p2Sync_ff);
  wire [3:0] p3Value = portToAcc(p3Sync_ff);
  wire [3:0] accValue = selectAcc(op, p2Value, p3Value, immediate, accNow);
  wire [3:0] yInc = wrapInc(yNow);
  wire yWraps = isZero(yInc);

  // Accumulator and pointer change only when a decoded word executes.
  // The skip request lasts one cycle, right after the wrapping increment.
  always_comb begin
    nxt_state.acc = accNow;
    nxt_state.yPtr = yNow;
    nxt_state.skipNext = 1'b0;
    if (accWrite) begin
      nxt_state.acc = accValue;
    end
    if (yWrite) begin
      nxt_state.yPtr = yInc;
      nxt_state.skipNext = yWraps;
    end
  end

  // A run stays open while consecutive valid words are immediate loads.
  assign nxt_lastLa = instrValid ? isLoad : lastLa_ff;

  // Carry only passes through and is never changed here.
  assign nxt_carry = carryIn;

  // Each pin pair passes two flops before any logic reads it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p2Meta_ff <= 2'b00;
    end else begin
      p2Meta_ff <= second_input_port;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p2Sync_ff <= 2'b00;
    end else begin
      p2Sync_ff <= p2Meta_ff;
    end
  end

  // Same for the third port.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p3Meta_ff <= 2'b00;
    end else begin
      p3Meta_ff <= third_input_port;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p3Sync_ff <= 2'b00;
    end else begin
      p3Sync_ff <= p3Meta_ff;
    end
  end

  // Accumulator, pointer and skip request, each cleared by reset.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= `PLIO_ACC_RST;
    end else begin
      acc_ff <= nxt_state.acc;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      y_ff <= `PLIO_Y_RST;
    end else begin
      y_ff <= nxt_state.yPtr;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_ff <= 1'b0;
    end else begin
      skip_ff <= nxt_state.skipNext;
    end
  end

  // Remembers whether the last valid word was an immediate load.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastLa_ff <= 1'b0;
    end else begin
      lastLa_ff <= nxt_lastLa;
    end
  end

  // Registered carry copy.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_ff <= 1'b0;
    end else begin
      carry_ff <= nxt_carry;
    end
  end

  // Every output comes straight from a flop.
  assign accOut = acc_ff;
  assign yOut = y_ff;
  assign skipNextOut = skip_ff;
  assign carryOut = carry_ff;
endmodule

// ### dv/plio_core_properties.sv
// Assertions on the plio_core ports.
// Bound into every plio_core instance.
module plio_core_chk
  import plio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire plio_instr_t instr,
  input wire logic [1:0] second_input_port,
  input wire logic [1:0] third_input_port,
  input wire logic carryIn,
  input wire logic [3:0] accOut,
  input wire logic [3:0] yOut,
  input wire logic skipNextOut,
  input wire logic carryOut
);
  wire isLa = instr.valid && instr.word[9:4] == 6'h07;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_port_two: assert property (instr == 11'h662 |=>
    accOut == $past(second_input_port, 3)) else $error("p2");
  chk_port_three: assert property (instr == 11'h663 |=>
    accOut == $past(third_input_port, 3)) else $error("p3");
  chk_y_inc: assert property (instr == 11'h413 |=>
    yOut == $past(yOut) + 4'h1 && $stable(accOut)) else $error("y");
  chk_y_skip: assert property (instr == 11'h413 |=>
    skipNextOut == ($past(yOut) == 4'hF)) else $error("sk");
  chk_la_first: assert property (isLa && $past(instr.valid) && !$past(isLa) |=>
    accOut == $past(instr.word[3:0])) else $error("la");
  chk_la_run: assert property (isLa && $past(isLa) |=> $stable(accOut))
    else $error("run");
  chk_carry_keep: assert property (carryOut == $past(carryIn))
    else $error("cy");
endmodule
bind plio_core plio_core_chk u_chk (.*);

// ### dv/plio_core_tb_top.sv
// Bench for plio_core.
// Drives every input itself.
module plio_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_n = 0, carryIn = 0;
  logic [10:0] instr = 0;
  logic [1:0] second_input_port = 0, third_input_port = 0;
  wire [3:0] accOut, yOut;
  wire skipNextOut, carryOut;
  int n_errors = 0, compares = 0;
  always #2 ref_clk = ~ref_clk;
  plio_core u_dut (.*);
  task chk(string s, logic [3:0] a, e);
    compares++;
    if (a !== e) begin n_errors++; $display("BAD %s exp %h saw %h", s, e, a); end
  endtask
  task op(logic v, logic [9:0] w); @(posedge ref_clk); instr <= {v, w}; endtask
  task end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task t_ports;
    op(1, 10'h07F); second_input_port <= 2'h3; third_input_port <= 2'h1; op(0, 0);
    op(1, 10'h262); op(0, 0);
    #1 chk("p2", accOut, 4'h3);
    op(1, 10'h07C); op(1, 10'h263); op(0, 0);
    #1 chk("p3", accOut, 4'h1);
  endtask
  task t_iny;
    for (int i = 1; i <= 16; i++) begin
      op(1, 10'h013); carryIn <= i[0]; op(0, 0);
      #1 chk("y", yOut, 4'(i));
      chk("sk", skipNextOut, i == 16);
      chk("cy", carryOut, i[0]);
    end
  endtask
  task t_la;
    op(1, 10'h000); op(1, 10'h075); op(1, 10'h079);
    #1 chk("la", accOut, 4'h5);
    op(0, 0); op(1, 10'h07A); op(1, 10'h000);
    #1 chk("run", accOut, 4'h5);
  endtask
  initial begin repeat (5) @(posedge ref_clk); rst_n <= 1; t_ports; t_iny; t_la; end_of_test; end
  initial begin #2000; n_errors++; end_of_test; end
endmodule
